/* design/mmc_pkg.sv */
// Constants for the miscellaneous control and status register bank:
// register indices, bit positions, reset values and bus widths.
// Assumes an APB master with 32-bit data; every register is one word.
//
// Behaviour
// - Gap segment one, bits 6:0, reset 0C.
// - Gap segment two, bits 6:0, reset 12.
// - Bits 7, 5, 4 drive ROM clock/data/select.
// - Bit 6 reads live ROM serial output.
// - Bit 3 drives MDIO when direction zero.
// - Bit 2 reads the MDIO pin level.
// - Bit 1 set releases MDIO as input.
// - Bit 0 drives the MDC clock pin.
// - Status bit 3: fast transmit in reset.
// - Status bit 2: slow logic in reset.
// - Status bit 1: whole PHY reset busy.
// - Status bit 0: autonegotiation done flag.
// - Input bits 6:4 return general inputs.
// - Input bits 2:0 give internal PHY status.
// - Control bit 6 forces PHY power-down.
// - Bit 5 picks media when bit 4 set.
// - Automatic media: external only if both down.
// - Output pin is inverse of bit 0.
// - Printer data drives only when enabled.
// - Offset 17 reads inputs, writes control.
// - Printer enable-low bit 5 resets to one.

package mmc_pkg;

	// Bus and register widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;
	localparam int IDX_W  = 6;

	// Register indices as printed; byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_GAP_ONE   = 6'h12;
	localparam logic [IDX_W-1:0] IDX_GAP_TWO   = 6'h13;
	localparam logic [IDX_W-1:0] IDX_MGMT      = 6'h14;
	localparam logic [IDX_W-1:0] IDX_TEST      = 6'h15;
	localparam logic [IDX_W-1:0] IDX_GEN_IO    = 6'h17;
	localparam logic [IDX_W-1:0] IDX_PRN_DATA  = 6'h18;
	localparam logic [IDX_W-1:0] IDX_PRN_CMD   = 6'h1A;

	// Management register bit positions.
	localparam int MG_ROM_CLOCK  = 7;
	localparam int MG_ROM_SOUT   = 6;
	localparam int MG_ROM_SIN    = 5;
	localparam int MG_ROM_SELECT = 4;
	localparam int MG_OUT        = 3;
	localparam int MG_IN         = 2;
	localparam int MG_DIRECTION  = 1;
	localparam int MG_CLOCK      = 0;

	// Test control write fields.
	localparam int TC_COLLISION = 4;
	localparam int TC_PIN_EN    = 3;
	localparam int TC_SEL_HI    = 2;

	// Phy reset status read bits.
	localparam int PS_FAST_TX  = 3;
	localparam int PS_SLOW     = 2;
	localparam int PS_BUSY     = 1;
	localparam int PS_AUTONEG  = 0;

	// General input read bits.
	localparam int GI_IN_HI    = 6;
	localparam int GI_IN_LO    = 4;
	localparam int GI_SPEED    = 2;
	localparam int GI_DUPLEX   = 1;
	localparam int GI_LINK     = 0;

	// Output and media control bits.
	localparam int OC_POWER_DOWN = 6;
	localparam int OC_MANUAL     = 5;
	localparam int OC_PRIORITY   = 4;
	localparam int OC_GEN_OUT    = 0;

	// Printer command bit for the active-low data output enable.
	localparam int PC_OE_N = 5;

	// Writable masks; reserved bits store nothing and read as zero.
	localparam logic [REG_W-1:0] MASK_GAP  = 8'h7F;
	localparam logic [REG_W-1:0] MASK_MGMT = 8'hBB;
	localparam logic [REG_W-1:0] MASK_TEST = 8'h1F;
	localparam logic [REG_W-1:0] MASK_OC   = 8'h71;
	localparam logic [REG_W-1:0] MASK_PCMD = 8'h3F;

	// Reset values.
	localparam logic [REG_W-1:0] RST_GAP_ONE  = 8'h0C;
	localparam logic [REG_W-1:0] RST_GAP_TWO  = 8'h12;
	localparam logic [REG_W-1:0] RST_MGMT     = 8'h02;
	localparam logic [REG_W-1:0] RST_ZERO     = 8'h00;
	localparam logic [REG_W-1:0] RST_PCMD     = 8'h20;

endpackage

/* design/mmc_field_reg.sv */
// One storage register of the bank with its own reset value and mask.
// Assumes the caller qualifies the write strobe with the bus handshake.

`timescale 1ns/1ps

module mmc_field_reg #(
	parameter int                 WIDTH    = 8,
	parameter logic [WIDTH-1:0]   RESET    = '0,
	parameter logic [WIDTH-1:0]   MASK     = '1
) (
	// Clock and reset.
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	// Write side.
	input  wire logic             i_write,
	input  wire logic [WIDTH-1:0] i_data,
	// Stored value.
	output logic      [WIDTH-1:0] o_value
);

	// Masked bits never change, so reserved bits stay at their reset zero.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_value <= RESET & MASK;
		end else if (i_write) begin
			o_value <= i_data & MASK;
		end
	end

endmodule

/* design/mmc_misc_regs.sv */
// Miscellaneous control and status register bank behind an APB slave:
// gap segments, bit-banged ROM and management pins, PHY status, media
// selection, a general output and the printer data port.
// Assumes all pin inputs are synchronous to i_clock and an APB master.

`timescale 1ns/1ps

module mmc_misc_regs (
	// Clock and reset.
	input  wire logic                          i_clock,
	input  wire logic                          i_rst_b,
	// APB slave.
	input  wire logic                          i_psel,
	input  wire logic                          i_penable,
	input  wire logic                          i_pwrite,
	input  wire logic [mmc_pkg::ADDR_W-1:0]    i_paddr,
	input  wire logic [mmc_pkg::DATA_W-1:0]    i_pwdata,
	output logic      [mmc_pkg::DATA_W-1:0]    o_prdata,
	output logic                               o_pready,
	output logic                               o_pslverr,
	// Serial ROM pins.
	output logic                               o_rom_clock,
	output logic                               o_rom_select,
	output logic                               o_rom_serial_in,
	input  wire logic                          i_rom_serial_out,
	// Management pins.
	output logic                               o_mgmt_clock,
	input  wire logic                          i_mdio,
	output logic                               o_mdio,
	output logic                               o_mdio_oe,
	// Internal PHY status.
	input  wire logic                          i_fast_tx_in_reset,
	input  wire logic                          i_slow_logic_in_reset,
	input  wire logic                          i_phy_reset_busy,
	input  wire logic                          i_autoneg_done,
	input  wire logic                          i_int_phy_speed,
	input  wire logic                          i_int_phy_duplex,
	input  wire logic                          i_int_phy_link,
	// General-purpose inputs and output.
	input  wire logic                          i_gen_input_two,
	input  wire logic                          i_gen_input_one,
	input  wire logic                          i_gen_input_zero,
	output logic                               o_gen_output_inv,
	// PHY and media control.
	output logic                               o_phy_power_down,
	output logic                               o_media_external,
	// Test controls.
	output logic                               o_collision_test,
	output logic                               o_test_pin_enable,
	output logic      [mmc_pkg::TC_SEL_HI:0]   o_test_pin_select,
	// Printer data port.
	input  wire logic [mmc_pkg::REG_W-1:0]     i_printer_data_bits,
	output logic      [mmc_pkg::REG_W-1:0]     o_printer_data_bits,
	output logic                               o_printer_data_oe
);

	import mmc_pkg::*;

	// Word index of the access and whether it is word aligned.
	logic [IDX_W-1:0]  acc_index;
	logic              acc_aligned;
	// Address decode hits.
	logic              hit_gap_one;
	logic              hit_gap_two;
	logic              hit_mgmt;
	logic              hit_test;
	logic              hit_gen_io;
	logic              hit_prn_data;
	logic              hit_prn_cmd;
	logic              acc_mapped;
	// Write strobe, true on the completing edge of a mapped write.
	logic              wr_fire;
	// Low byte of the write data.
	logic [REG_W-1:0]  wr_byte;
	// Stored register values.
	logic [REG_W-1:0]  gap_segment_one;
	logic [REG_W-1:0]  gap_segment_two;
	logic [REG_W-1:0]  serial_mgmt_pins;
	logic [REG_W-1:0]  test_control;
	logic [REG_W-1:0]  output_media_control;
	logic [REG_W-1:0]  printer_data_port;
	logic [REG_W-1:0]  printer_command;
	// Read views assembled from live inputs.
	logic [REG_W-1:0]  phy_reset_status;
	logic [REG_W-1:0]  general_inputs;
	logic [REG_W-1:0]  mgmt_read;
	// Next values for registered outputs.
	logic [DATA_W-1:0] next_prdata;
	logic              next_media_external;

	// Decode: the printed offsets are word indices, so the byte address
	// is the index shifted up by two and the low two bits must be zero.
	assign acc_index    = i_paddr[ADDR_W-1:2];
	assign acc_aligned  = (i_paddr[1:0] == 2'h0);
	assign hit_gap_one  = acc_aligned && (acc_index == IDX_GAP_ONE);
	assign hit_gap_two  = acc_aligned && (acc_index == IDX_GAP_TWO);
	assign hit_mgmt     = acc_aligned && (acc_index == IDX_MGMT);
	assign hit_test     = acc_aligned && (acc_index == IDX_TEST);
	assign hit_gen_io   = acc_aligned && (acc_index == IDX_GEN_IO);
	assign hit_prn_data = acc_aligned && (acc_index == IDX_PRN_DATA);
	assign hit_prn_cmd  = acc_aligned && (acc_index == IDX_PRN_CMD);
	assign acc_mapped   = hit_gap_one | hit_gap_two | hit_mgmt | hit_test |
	                      hit_gen_io | hit_prn_data | hit_prn_cmd;

	// A write lands only on the edge where the master sees pready high.
	// Unmapped writes are dropped and answered with an error.
	assign wr_fire = i_psel && i_penable && i_pwrite && o_pready &&
	                 acc_mapped;
	assign wr_byte = i_pwdata[REG_W-1:0];

	// APB answer: one wait state, so pready rises in the second access
	// cycle. This gives read data a full cycle to settle in a flop.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= i_psel && i_penable && !o_pready;
		end
	end

	// Error flag for unaligned or unmapped addresses, valid with pready.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= i_psel && i_penable && !o_pready && !acc_mapped;
		end
	end

	// Gap segment one storage.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_GAP_ONE),
		.MASK  (MASK_GAP)
	) u_gap_one (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_gap_one),
		.i_data  (wr_byte),
		.o_value (gap_segment_one)
	);

	// Gap segment two storage.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_GAP_TWO),
		.MASK  (MASK_GAP)
	) u_gap_two (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_gap_two),
		.i_data  (wr_byte),
		.o_value (gap_segment_two)
	);

	// Management pin storage; the mask drops writes to the two
	// read-only bits so they never hold a stale value.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_MGMT),
		.MASK  (MASK_MGMT)
	) u_mgmt (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_mgmt),
		.i_data  (wr_byte),
		.o_value (serial_mgmt_pins)
	);

	// Test control storage, written at the shared status offset.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_ZERO),
		.MASK  (MASK_TEST)
	) u_test (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_test),
		.i_data  (wr_byte),
		.o_value (test_control)
	);

	// Output and media control, written where general inputs are read.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_ZERO),
		.MASK  (MASK_OC)
	) u_out_ctrl (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_gen_io),
		.i_data  (wr_byte),
		.o_value (output_media_control)
	);

	// Printer data output latch.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_ZERO),
		.MASK  (8'hFF)
	) u_prn_data (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_prn_data),
		.i_data  (wr_byte),
		.o_value (printer_data_port)
	);

	// Printer command; the output enable resets high, so the port
	// comes up as an input and cannot fight a driving printer.
	mmc_field_reg #(
		.WIDTH (REG_W),
		.RESET (RST_PCMD),
		.MASK  (MASK_PCMD)
	) u_prn_cmd (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_write (wr_fire && hit_prn_cmd),
		.i_data  (wr_byte),
		.o_value (printer_command)
	);

	// PHY reset status view: all four bits are live indications.
	always_comb begin
		phy_reset_status             = '0;
		phy_reset_status[PS_FAST_TX] = i_fast_tx_in_reset;
		phy_reset_status[PS_SLOW]    = i_slow_logic_in_reset;
		phy_reset_status[PS_BUSY]    = i_phy_reset_busy;
		// The PHY drops its done level on restart; it is passed through.
		phy_reset_status[PS_AUTONEG] = i_autoneg_done;
	end

	// General input view: external PHY hints above, internal below.
	always_comb begin
		general_inputs                      = '0;
		general_inputs[GI_IN_HI:GI_IN_LO]   = {i_gen_input_two,
		                                       i_gen_input_one,
		                                       i_gen_input_zero};
		general_inputs[GI_SPEED]            = i_int_phy_speed;
		general_inputs[GI_DUPLEX]           = i_int_phy_duplex;
		general_inputs[GI_LINK]             = i_int_phy_link;
	end

	// Management view: stored bits plus live pin levels.
	always_comb begin
		mgmt_read               = serial_mgmt_pins;
		mgmt_read[MG_ROM_SOUT]  = i_rom_serial_out;
		mgmt_read[MG_IN]        = i_mdio;
	end

	// Read data mux; unmapped reads return zero along with the error.
	always_comb begin
		next_prdata = '0;
		if (hit_gap_one) begin
			next_prdata[REG_W-1:0] = gap_segment_one;
		end else if (hit_gap_two) begin
			next_prdata[REG_W-1:0] = gap_segment_two;
		end else if (hit_mgmt) begin
			next_prdata[REG_W-1:0] = mgmt_read;
		end else if (hit_test) begin
			// Test controls are write only; reads show status.
			next_prdata[REG_W-1:0] = phy_reset_status;
		end else if (hit_gen_io) begin
			next_prdata[REG_W-1:0] = general_inputs;
		end else if (hit_prn_data) begin
			// The pins are read back, whichever way they are driven.
			next_prdata[REG_W-1:0] = i_printer_data_bits;
		end else if (hit_prn_cmd) begin
			next_prdata[REG_W-1:0] = printer_command;
		end
	end

	// Read data are caught in the cycle that raises pready and hold
	// until the next read; pins are sampled one cycle before the end.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prdata <= '0;
		end else if (i_psel && i_penable && !o_pready && !i_pwrite) begin
			o_prdata <= next_prdata;
		end
	end

	// Serial ROM pins follow the stored bits one cycle after a write.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rom_clock     <= 1'b0;
			o_rom_select    <= 1'b0;
			o_rom_serial_in <= 1'b0;
		end else begin
			o_rom_clock     <= serial_mgmt_pins[MG_ROM_CLOCK];
			o_rom_select    <= serial_mgmt_pins[MG_ROM_SELECT];
			o_rom_serial_in <= serial_mgmt_pins[MG_ROM_SIN];
		end
	end

	// Management clock and data. Software owns all timing, so the extra
	// cycle of pin latency is far below any bit-bang period.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mgmt_clock <= 1'b0;
			o_mdio       <= 1'b0;
			o_mdio_oe    <= 1'b0;
		end else begin
			o_mgmt_clock <= serial_mgmt_pins[MG_CLOCK];
			o_mdio       <= serial_mgmt_pins[MG_OUT];
			// Direction set releases the pin so the PHY may drive it.
			o_mdio_oe    <= !serial_mgmt_pins[MG_DIRECTION];
		end
	end

	// Test outputs; left at zero unless software disobeys the advice.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_collision_test  <= 1'b0;
			o_test_pin_enable <= 1'b0;
			o_test_pin_select <= '0;
		end else begin
			o_collision_test  <= test_control[TC_COLLISION];
			o_test_pin_enable <= test_control[TC_PIN_EN];
			o_test_pin_select <= test_control[TC_SEL_HI:0];
		end
	end

	// Media choice: manual when priority bit is set, else external only
	// when neither the internal link nor the external link hint is up.
	always_comb begin
		if (output_media_control[OC_PRIORITY]) begin
			next_media_external = output_media_control[OC_MANUAL];
		end else begin
			next_media_external = !i_int_phy_link &&
			                      !i_gen_input_zero;
		end
	end

	// PHY power, media and general output pins.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_phy_power_down <= 1'b0;
			o_media_external <= 1'b0;
			// Stored bit resets to zero, so the inverted pin starts high.
			o_gen_output_inv <= 1'b1;
		end else begin
			o_phy_power_down <= output_media_control[OC_POWER_DOWN];
			o_media_external <= next_media_external;
			o_gen_output_inv <= !output_media_control[OC_GEN_OUT];
		end
	end

	// Printer data port: drives only after the active-low enable clears.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_printer_data_bits <= '0;
			o_printer_data_oe   <= 1'b0;
		end else begin
			o_printer_data_bits <= printer_data_port;
			o_printer_data_oe   <= !printer_command[PC_OE_N];
		end
	end

endmodule

/* tb/mmc_misc_regs_sva.sv */
// Checker for the register bank: bus answers and pins that follow writes.
// Assumes a master that keeps setup then access order on the bus.
`timescale 1ns/1ps
module mmc_misc_regs_sva import mmc_pkg::*; (
	// Clock, reset and bus.
	input wire logic              i_clock,
	input wire logic              i_rst_b,
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [DATA_W-1:0] i_pwdata,
	input wire logic [DATA_W-1:0] o_prdata,
	input wire logic              o_pready,
	input wire logic              o_pslverr,
	// Pins and status.
	input wire logic              o_rom_clock,
	input wire logic              o_rom_select,
	input wire logic              o_rom_serial_in,
	input wire logic              o_mgmt_clock,
	input wire logic              o_mdio,
	input wire logic              o_mdio_oe,
	input wire logic              i_fast_tx_in_reset,
	input wire logic              i_slow_logic_in_reset,
	input wire logic              i_phy_reset_busy,
	input wire logic              i_autoneg_done,
	input wire logic              o_gen_output_inv,
	input wire logic              o_phy_power_down,
	input wire logic              o_media_external,
	input wire logic              o_printer_data_oe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// First cycle of an access phase.
	sequence acc_s;
		i_psel && i_penable && !$past(i_penable);
	endsequence
	// Start of a status read.
	sequence rd54_s;
		acc_s ##0 (!i_pwrite && i_paddr == 8'h54);
	endsequence
	// Read data equals the levels seen in the first access cycle.
	sequence stat_s;
		o_prdata[3:0] == $past({i_fast_tx_in_reset, i_slow_logic_in_reset,
			i_phy_reset_busy, i_autoneg_done});
	endsequence
	// A write completing at this edge to byte address a.
	sequence wr_s(logic [7:0] a);
		i_psel && i_penable && o_pready && i_pwrite && i_paddr == a;
	endsequence
	// Pins are checked three edges on, after the extra pin stage.
	status_rd_a: assert property (rd54_s |=> o_pready ##0 stat_s)
		else $error("status read data wrong");
	bad_addr_a: assert property (acc_s ##0 i_paddr[1:0] != 2'h0
		|=> o_pready && o_pslverr && (i_pwrite || o_prdata == 32'h0))
		else $error("unaligned access not refused");
	mgmt_pins_a: assert property (wr_s(8'h50) |-> ##3
		o_mgmt_clock == $past(i_pwdata[0], 3) && o_mdio == $past(i_pwdata[3], 3))
		else $error("management pins do not follow write");
	mdio_dir_a: assert property (wr_s(8'h50) |-> ##3
		o_mdio_oe != $past(i_pwdata[1], 3)) else $error("mdio direction wrong");
	rom_pins_a: assert property (wr_s(8'h50) |-> ##3
		{o_rom_clock, o_rom_serial_in, o_rom_select}
		== $past({i_pwdata[7], i_pwdata[5:4]}, 3)) else $error("rom pins wrong");
	gen_out_a: assert property (wr_s(8'h5C) |-> ##3
		o_gen_output_inv != $past(i_pwdata[0], 3)
		&& o_phy_power_down == $past(i_pwdata[6], 3))
		else $error("output or power-down pin wrong");
	media_set_a: assert property (wr_s(8'h5C) ##0 i_pwdata[4] |-> ##3
		o_media_external == $past(i_pwdata[5], 3)) else $error("manual media");
	printer_oe_a: assert property (wr_s(8'h68) |-> ##3
		o_printer_data_oe != $past(i_pwdata[5], 3)) else $error("printer enable");
endmodule

bind mmc_misc_regs mmc_misc_regs_sva chk_u (.i_clock, .i_rst_b, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
	.o_pslverr, .o_rom_clock, .o_rom_select, .o_rom_serial_in, .o_mgmt_clock,
	.o_mdio, .o_mdio_oe, .i_fast_tx_in_reset, .i_slow_logic_in_reset,
	.i_phy_reset_busy, .i_autoneg_done, .o_gen_output_inv, .o_phy_power_down,
	.o_media_external, .o_printer_data_oe);

/* tb/mmc_pins_model.sv */
// Far-side model: management PHY, serial ROM and printer on their wires.
// Assumes the bench chooses the values that the far side offers.
`timescale 1ns/1ps
module mmc_pins_model (
	// Clock.
	input  wire logic       i_clock,
	// Device pins.
	input  wire logic       i_mdio,
	input  wire logic       i_mdio_oe,
	input  wire logic       i_rom_select,
	input  wire logic [7:0] i_prn,
	input  wire logic       i_prn_oe,
	// Values the far side offers.
	input  wire logic       i_phy_bit,
	input  wire logic       i_rom_bit,
	input  wire logic [7:0] i_prn_drive,
	// Resolved wire levels.
	output logic            o_mdio,
	output logic            o_rom_out,
	output logic [7:0]      o_prn
);
	logic rom_last = 1'b0; // Last bit the ROM put out while selected.
	// The PHY drives the data line only while the device releases it.
	assign o_mdio = i_mdio_oe ? i_mdio : i_phy_bit;
	// A deselected ROM floats, so show the inverse of its last bit.
	assign o_rom_out = i_rom_select ? i_rom_bit : ~rom_last;
	// The printer drives its lines whenever the device does not.
	assign o_prn = i_prn_oe ? i_prn : i_prn_drive;
	// Remember what the ROM drove.
	always_ff @(posedge i_clock) begin
		if (i_rom_select) begin
			rom_last <= i_rom_bit;
		end
	end
endmodule

/* tb/mmc_misc_regs_tb.sv */
// Self-checking bench for the register bank, driven over APB.
// Assumes the pin model and the checker are compiled before it.
`timescale 1ns/1ps
module mmc_misc_regs_tb;
	// Bus, pins and far-side offers.
	logic        i_clock = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0;
	logic        i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00, prn_drive = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	logic [3:0]  stat = 4'h0; // PHY reset and autonegotiation levels.
	logic [2:0]  gen = 3'h0, phy = 3'h0; // General inputs, PHY status.
	logic        phy_bit = 1'b0, rom_bit = 1'b0;
	logic        o_pready, o_pslverr, o_rom_clock, o_rom_select;
	logic        o_rom_serial_in, o_mgmt_clock, o_mdio, o_mdio_oe;
	logic        o_gen_output_inv, o_phy_power_down, o_media_external;
	logic        o_collision_test, o_test_pin_enable, o_printer_data_oe;
	logic        i_mdio, i_rom_serial_out;
	logic [2:0]  o_test_pin_select;
	logic [7:0]  o_printer_data_bits, i_printer_data_bits;
	int          num_errors = 0, n_tests = 0;

	mmc_misc_regs dut_u (.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_rom_clock,
		.o_rom_select, .o_rom_serial_in, .i_rom_serial_out, .o_mgmt_clock,
		.i_mdio, .o_mdio, .o_mdio_oe, .i_fast_tx_in_reset(stat[3]),
		.i_slow_logic_in_reset(stat[2]), .i_phy_reset_busy(stat[1]),
		.i_autoneg_done(stat[0]), .i_int_phy_speed(phy[2]),
		.i_int_phy_duplex(phy[1]), .i_int_phy_link(phy[0]),
		.i_gen_input_two(gen[2]), .i_gen_input_one(gen[1]),
		.i_gen_input_zero(gen[0]), .o_gen_output_inv, .o_phy_power_down,
		.o_media_external, .o_collision_test, .o_test_pin_enable,
		.o_test_pin_select, .i_printer_data_bits, .o_printer_data_bits,
		.o_printer_data_oe);
	mmc_pins_model pins_u (.i_clock, .i_mdio(o_mdio), .i_mdio_oe(o_mdio_oe),
		.i_rom_select(o_rom_select), .i_prn(o_printer_data_bits),
		.i_prn_oe(o_printer_data_oe), .i_phy_bit(phy_bit),
		.i_rom_bit(rom_bit), .i_prn_drive(prn_drive), .o_mdio(i_mdio),
		.o_rom_out(i_rom_serial_out), .o_prn(i_printer_data_bits));

	always #5 i_clock = ~i_clock;

	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [32:0] g, input logic [32:0] x);
		n_tests++;
		if (g !== x) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// One transfer; upper data bits are noise the bank must ignore.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= {24'h5A5A5A, d};
		@(posedge i_clock);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 20);
		q = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			$display("CHECK FAILED at %0t: no ready", $time);
		end
	endtask
	// Writes a register and lets its pins settle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk({32'h0, e}, 33'h0);
		repeat (2) @(posedge i_clock);
	endtask
	// Reads a register and compares it with a byte.
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 8'h00, q, e);
		chk({e, q}, {25'h0, x});
	endtask
	// Reset values, stored widths and refused addresses.
	task automatic t_regs();
		logic [31:0] q;
		logic        e;
		chk({o_gen_output_inv, o_printer_data_oe}, 2'h2);
		chk({o_phy_power_down, o_mdio_oe}, 2'h0);
		rd(8'h48, 8'h0C);
		rd(8'h4C, 8'h12);
		rd(8'h68, 8'h20);
		wr(8'h48, 8'hFF);
		rd(8'h48, 8'h7F);
		wr(8'h4C, 8'h80);
		// A write leaves the read data alone, so only the error is judged.
		apb(1'b1, 8'h4E, 8'hFF, q, e);
		chk(e, 1'b1);
		apb(1'b0, 8'h4E, 8'h00, q, e);
		chk({e, q}, {1'b1, 32'h0});
		rd(8'h4C, 8'h00);
		$display("test regs done");
	endtask
	// Bit-banged pins, live read-back and ignored read-only bits.
	task automatic t_mgmt();
		logic [7:0] p [4] = '{8'hFF, 8'h00, 8'hA9, 8'h56};
		foreach (p[k]) begin
			phy_bit <= k[0];
			rom_bit <= ~k[0];
			wr(8'h50, p[k]);
			chk({o_rom_clock, o_rom_serial_in, o_rom_select, o_mdio, o_mdio_oe,
				o_mgmt_clock}, {p[k][7], p[k][5:3], ~p[k][1], p[k][0]});
			rd(8'h50, {p[k][7], i_rom_serial_out, p[k][5:3],
				p[k][1] ? phy_bit : p[k][3], p[k][1:0]});
		end
		$display("test mgmt done");
	endtask
	// Test bits out, PHY reset and autonegotiation levels back.
	task automatic t_test();
		wr(8'h54, 8'h1F);
		chk({o_collision_test, o_test_pin_enable, o_test_pin_select}, 5'h1F);
		wr(8'h54, 8'h00);
		for (int k = 0; k < 4; k++) begin
			stat <= 4'h1 << k;
			rd(8'h54, 8'h01 << k);
		end
		$display("test status done");
	endtask
	// Media choice, power-down, inverted output, then input reads.
	task automatic t_media();
		wr(8'h5C, 8'h30);
		chk(o_media_external, 1'b1);
		wr(8'h5C, 8'h51);
		chk({o_media_external, o_phy_power_down, o_gen_output_inv}, 3'h2);
		wr(8'h5C, 8'h00);
		for (int k = 0; k < 4; k++) begin
			{phy[0], gen[0]} <= k[1:0];
			repeat (2) @(posedge i_clock);
			chk(o_media_external, k == 0);
		end
		for (int k = 0; k < 8; k++) begin
			gen <= k[2:0];
			phy <= ~k[2:0];
			rd(8'h5C, {1'b0, k[2:0], 1'b0, ~k[2:0]});
		end
		$display("test media done");
	endtask
	// Printer lines are input until the enable bit is cleared.
	task automatic t_prn();
		prn_drive <= 8'h3C;
		wr(8'h60, 8'hA5);
		rd(8'h60, 8'h3C);
		wr(8'h68, 8'h00);
		chk({o_printer_data_oe, o_printer_data_bits}, 9'h1A5);
		rd(8'h60, 8'hA5);
		$display("test printer done");
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("compares %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence after ten cycles of reset.
	initial begin
		repeat (10) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		t_regs();
		t_mgmt();
		t_test();
		t_media();
		t_prn();
		final_report();
	end
	// Watchdog; the tests need well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge i_clock);
		num_errors++;
		final_report();
	end
endmodule
